/* design/avalon_reg_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// avalon-mm slave: every access answered one cycle after taken
// ==========================================================
module avalon_reg_slave
  import board_ctrl_pkg::*;
(
  input wire logic clock,                 // system clock
  input wire logic arst_n,                // async reset, active low
  input wire logic [addr_w-1:0] address,  // byte address
  input wire logic read,                  // read request
  input wire logic write,                 // write request
  input wire logic [31:0] writedata,      // write data
  input wire logic [3:0] byteenable,      // byte lanes
  output logic [31:0] readdata,           // read data
  output logic waitrequest,               // stall until answer
  reg_access_if.slave acc                 // decoded access
);
  bus_state_t state;                      // answer state
  // state machine: one wait cycle, then release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: if (read || write) state <= st_done;
        st_done: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end
  // waitrequest is high at rest so a new request always stalls once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(state == st_idle && (read || write));
    end
  end
  // read data captured with the answer; revision sampled here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= '0;
    end else if (state == st_idle && read) begin
      readdata <= {24'h000000, acc.rdata};
    end
  end
  assign acc.addr = address;
  assign acc.wdata = writedata[data_w-1:0];
  // write lands on the edge where waitrequest is sampled low
  assign acc.wr_stb = (state == st_done) && write && byteenable[0];
endmodule // avalon_reg_slave
`default_nettype wire

/* design/board_ctrl_output_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - lamp bits 0..3 drive lamp pins
// - first timeout bit0 drives enable pin
// - first timeout bit1 drives write pin
// - second timeout at 0x21, bit0 enable
// - second timeout bit1 drives write pin
// - revision at 0x22 reads pins, read-only
// - revision bits sampled live at read
module board_ctrl_output_regs
  import board_ctrl_pkg::*;
(
  input wire logic clock,                      // 100 MHz clock
  input wire logic arst_n,                     // async reset, active low
  input wire logic [addr_w-1:0] address,       // avalon byte address
  input wire logic read,                       // avalon read
  input wire logic write,                      // avalon write
  input wire logic [31:0] writedata,           // avalon write data
  input wire logic [3:0] byteenable,           // avalon byte enables
  output logic [31:0] readdata,                // avalon read data
  output logic waitrequest,                    // avalon wait
  input wire logic [7:0] revision_input_pins,  // revision straps
  output logic [lamp_count-1:0] lamp_pin,      // lamp pins 0..3
  output logic timeout_first_enable_pin,       // first timeout enable
  output logic timeout_first_write_pin,        // first timeout write
  output logic timeout_second_enable_pin,      // second timeout enable
  output logic timeout_second_write_pin        // second timeout write
);
  // ==========================================================
  // bus slave
  // ==========================================================
  reg_access_if acc ();                        // decoded access
  avalon_reg_slave u_slave (
    .clock(clock),
    .arst_n(arst_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .acc(acc)
  );
  // ==========================================================
  // register bank
  // ==========================================================
  logic [7:0] indicator_lamp_ctrl;             // lamp register
  logic [7:0] boot_timeout_ctrl_first;         // first timeout register
  logic [7:0] boot_timeout_ctrl_second;        // second timeout register

  // write hit test, shared by all writable registers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      indicator_lamp_ctrl <= ctrl_reset;
    end else if (acc.wr_stb && hit(acc.addr, lamp_reg_addr)) begin
      indicator_lamp_ctrl <= acc.wdata;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_timeout_ctrl_first <= ctrl_reset;
    end else if (acc.wr_stb && hit(acc.addr, tmo_first_addr)) begin
      boot_timeout_ctrl_first <= acc.wdata;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_timeout_ctrl_second <= ctrl_reset;
    end else if (acc.wr_stb && hit(acc.addr, tmo_second_addr)) begin
      boot_timeout_ctrl_second <= acc.wdata;
    end
  end

  // read mux; revision writes fall through with no effect
  always_comb begin
    case (acc.addr)
      lamp_reg_addr: acc.rdata = indicator_lamp_ctrl;
      tmo_first_addr: acc.rdata = boot_timeout_ctrl_first;
      tmo_second_addr: acc.rdata = boot_timeout_ctrl_second;
      revision_addr: acc.rdata = revision_input_pins;
      default: acc.rdata = unmapped_read;
    endcase
  end

  // ==========================================================
  // pin drivers, registered so outputs come from flip-flops
  // ==========================================================
  // pins follow registers one cycle later; the added lag is harmless
  // for slow board controls and keeps the outputs glitch free
  genvar i;
  generate
    for (i = 0; i < lamp_count; i++) begin : g_lamp
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          lamp_pin[i] <= 1'b0;
        end else begin
          lamp_pin[i] <= indicator_lamp_ctrl[i];
        end
      end
    end
  endgenerate

  // timeout pins from their control bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timeout_first_enable_pin <= 1'b0;
      timeout_first_write_pin <= 1'b0;
      timeout_second_enable_pin <= 1'b0;
      timeout_second_write_pin <= 1'b0;
    end else begin
      timeout_first_enable_pin <= boot_timeout_ctrl_first[tmo_enable_bit];
      timeout_first_write_pin <= boot_timeout_ctrl_first[tmo_write_bit];
      timeout_second_enable_pin <= boot_timeout_ctrl_second[tmo_enable_bit];
      timeout_second_write_pin <= boot_timeout_ctrl_second[tmo_write_bit];
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  sequence s_write_second;
    acc.wr_stb && acc.addr == tmo_second_addr;
  endsequence
  a_lamp_pins_follow: assert property (
    @(posedge clock) disable iff (!arst_n)
    lamp_pin == $past(indicator_lamp_ctrl[lamp_count-1:0]))
    else $error("lamp pins do not follow register");
  a_first_enable_pin: assert property (
    @(posedge clock) disable iff (!arst_n)
    acc.wr_stb && acc.addr == tmo_first_addr
    |=> ##1 timeout_first_enable_pin == $past(acc.wdata[0], 2))
    else $error("first enable pin wrong after write");
  a_first_write_pin: assert property (
    @(posedge clock) disable iff (!arst_n)
    acc.wr_stb && acc.addr == tmo_first_addr
    |=> ##1 timeout_first_write_pin == $past(acc.wdata[1], 2))
    else $error("first write pin wrong after write");
  a_second_enable_pin: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_write_second |=> ##1
    timeout_second_enable_pin == $past(acc.wdata[0], 2))
    else $error("second enable pin wrong after write");
  a_second_write_pin: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_write_second |=> ##1
    timeout_second_write_pin == $past(acc.wdata[1], 2))
    else $error("second write pin wrong after write");
  a_revision_read: assert property (
    @(posedge clock) disable iff (!arst_n)
    read && !waitrequest && $past(address) == revision_addr
    && $past(read) |-> readdata[7:0] == $past(revision_input_pins))
    else $error("revision read does not match pins");
  a_revision_upper: assert property (
    @(posedge clock) disable iff (!arst_n)
    !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_reserved_kept: assert property (
    @(posedge clock) disable iff (!arst_n)
    acc.wr_stb && acc.addr == lamp_reg_addr
    |=> indicator_lamp_ctrl == $past(acc.wdata))
    else $error("lamp register lost written byte");
endmodule // board_ctrl_output_regs
`default_nettype wire

/* design/board_ctrl_pkg.sv */
`default_nettype none
package board_ctrl_pkg;
  // ==========================================================
  // register map (byte addresses on the avalon bus)
  // ==========================================================
  localparam logic [7:0] lamp_reg_addr = 8'h1F;     // lamp control
  localparam logic [7:0] tmo_first_addr = 8'h20;    // first timeout ctrl
  localparam logic [7:0] tmo_second_addr = 8'h21;   // second timeout ctrl
  localparam logic [7:0] revision_addr = 8'h22;     // revision, read only
  localparam int addr_w = 8;                        // bus address width
  localparam int data_w = 8;                        // register width
  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int lamp_count = 4;                    // lamp pins
  localparam int tmo_enable_bit = 0;                // enable pin bit
  localparam int tmo_write_bit = 1;                 // write pin bit
  localparam logic [7:0] ctrl_reset = 8'h00;        // writable reset value
  localparam logic [7:0] unmapped_read = 8'h00;     // unmapped answer
  // ==========================================================
  // bus answer states
  // ==========================================================
  typedef enum logic [1:0] {
    st_idle = 2'b01,                                // waiting for request
    st_done = 2'b10                                 // answer this cycle
  } bus_state_t;
endpackage
`default_nettype wire

/* design/reg_access_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// decoded register access between bus slave and register bank
// ==========================================================
interface reg_access_if;
  logic wr_stb;        // one-cycle write strobe
  logic [7:0] addr;    // byte address
  logic [7:0] wdata;   // write data
  logic [7:0] rdata;   // read data for addr
  modport slave (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* testbench/board_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// board side: revision straps and the lamp and timeout loads
// ==========================================================
module board_pin_model
  import board_ctrl_pkg::*;
(
  input wire logic [7:0] strap_level,           // straps fitted
  input wire logic [lamp_count-1:0] lamp_pin,   // lamp loads
  input wire logic timeout_first_enable_pin,    // first enable load
  input wire logic timeout_first_write_pin,     // first write load
  input wire logic timeout_second_enable_pin,   // second enable load
  input wire logic timeout_second_write_pin,    // second write load
  output logic [7:0] revision_input_pins,       // strap levels to fpga
  output logic [7:0] pin_word                   // all loads as one byte
);
  // straps follow strap_level, which the bench changes mid run
  // straps are hard wired, so a level is always driven, never floats
  assign revision_input_pins = strap_level;
  assign pin_word = {timeout_second_write_pin, timeout_second_enable_pin,
                     timeout_first_write_pin, timeout_first_enable_pin,
                     lamp_pin};
endmodule // board_pin_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench: register tasks over avalon, pins seen via board model
// ==========================================================
module tb_top
  import board_ctrl_pkg::*;
;
  logic clock = 1'b0;           // 100 MHz
  logic arst_n = 1'b0;          // async reset, active low
  logic [7:0] address = 8'h00;  // bus address
  logic read = 1'b0;            // bus read
  logic write = 1'b0;           // bus write
  logic [31:0] writedata = 32'h00000000; // bus write data
  logic [3:0] byteenable = 4'hF;         // bus lanes
  logic [31:0] readdata;        // bus read data
  logic waitrequest;            // bus stall
  logic [7:0] strap_level = 8'hA5;       // revision straps
  logic [7:0] rev_pins;         // straps into the bank
  logic [7:0] pin_word;         // loads as one byte
  logic [3:0] lamp_pin;         // lamp pins
  logic te1, tw1, te2, tw2;     // timeout pins
  logic [31:0] rd;              // last read value
  int mismatches = 0;           // failed compares
  int compares = 0;             // all compares
  // table of writes: address, data, pins expected afterwards
  logic [7:0] t_a [7] = '{lamp_reg_addr, lamp_reg_addr, tmo_first_addr,
    tmo_first_addr, tmo_second_addr, tmo_second_addr, lamp_reg_addr};
  logic [7:0] t_d [7] = '{8'h0A, 8'hF5, 8'h01, 8'hFE, 8'h02, 8'hFD, 8'h00};
  logic [7:0] t_p [7] = '{8'h0A, 8'h05, 8'h15, 8'h25, 8'hA5, 8'h65, 8'h60};

  board_ctrl_output_regs dut (.clock(clock), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .revision_input_pins(rev_pins), .lamp_pin(lamp_pin),
    .timeout_first_enable_pin(te1), .timeout_first_write_pin(tw1),
    .timeout_second_enable_pin(te2), .timeout_second_write_pin(tw2));
  board_pin_model board (.strap_level(strap_level), .lamp_pin(lamp_pin),
    .timeout_first_enable_pin(te1), .timeout_first_write_pin(tw1),
    .timeout_second_enable_pin(te2), .timeout_second_write_pin(tw2),
    .revision_input_pins(rev_pins), .pin_word(pin_word));

  // free running clock
  initial begin
    forever #5 clock = ~clock;
  end
  // verdict and end of run
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one compare, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= be;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // a slave that never answers ends the run here
    if (waitrequest !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // pins follow the register one clock after the write lands
  task automatic pins_chk(input logic [7:0] exp);
    @(posedge clock);
    #1;
    check({24'h000000, pin_word}, {24'h000000, exp});
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    // reset values of the writable registers, pins dark
    for (int i = 0; i < 3; i++) begin
      access(1'b0, t_a[i * 2], 8'h00, 4'hF);
      check(rd, {24'h000000, ctrl_reset});
    end
    pins_chk(8'h00);
    // each pin bit at both levels, reserved bits read back
    for (int i = 0; i < 7; i++) begin
      access(1'b1, t_a[i], t_d[i], 4'hF);
      pins_chk(t_p[i]);
      access(1'b0, t_a[i], 8'h00, 4'hF);
      check(rd, {24'h000000, t_d[i]});
    end
    // low lane disabled: write answered but dropped
    access(1'b1, lamp_reg_addr, 8'hFF, 4'hE);
    access(1'b0, lamp_reg_addr, 8'h00, 4'hF);
    check(rd, 32'h00000000);
    // unmapped place keeps nothing
    access(1'b1, 8'h30, 8'hFF, 4'hF);
    access(1'b0, 8'h30, 8'h00, 4'hF);
    check(rd, {24'h000000, unmapped_read});
    // revision follows the straps live, writes do nothing
    access(1'b0, revision_addr, 8'h00, 4'hF);
    check(rd, 32'h000000A5);
    strap_level <= 8'h5A;
    access(1'b1, revision_addr, 8'hFF, 4'hF);
    pins_chk(8'h60);
    access(1'b0, revision_addr, 8'h00, 4'hF);
    check(rd, 32'h0000005A);
    // second reset in mid run drops every pin
    access(1'b1, lamp_reg_addr, 8'h0F, 4'hF);
    pins_chk(8'h6F);
    // reset is raised and dropped on rising edges, like any other input
    @(posedge clock);
    arst_n <= 1'b0;
    pins_chk(8'h00);
    @(posedge clock);
    arst_n <= 1'b1;
    // after release the bus answers again, the lamp register reads its reset value and pins stay dark
    access(1'b0, lamp_reg_addr, 8'h00, 4'hF);
    check(rd, {24'h000000, ctrl_reset});
    pins_chk(8'h00);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
